// ===== rtl/acdp_top.v
// Paired-input converter control: divider select, pair-ready flags,
// base pointer upper byte and an interrupt, behind an Avalon-MM slave.
// Assumes the converter core runs on clk_sys; pll_enable is asynchronous.
// Assumes the bus master holds each request until it sees waitrequest
// low and drops it on that same edge; every access takes two cycles.
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "acdp_regs.vh"

// What this block does
// - Codes 111 to 010 divide the source clock by 18,16,14,12,10,8.
// - With PLL on, codes 001 and 000 run at the divide-by-eight rate.
// - With PLL off, code 001 divides by six and 000 by four.
// - Status holds pair flags at bits 0 to 5; upper bits read zero.
// - A flag sets when its pair's results land in the buffer; reset clears.
// - Writing zero to a flag clears it; writing one leaves it.
module acdp_top (
    input  wire        clk_sys,          // 10 MHz system clock
    input  wire        rst,              // Synchronous reset, active high
    input  wire [7:0]  avs_address,      // Byte address
    input  wire        avs_read,         // Read request
    input  wire        avs_write,        // Write request
    input  wire [31:0] avs_writedata,    // Write data
    input  wire [3:0]  avs_byteenable,   // Write byte lanes
    output reg  [31:0] avs_readdata,     // Read data
    output reg         avs_waitrequest,  // Stall, low for one answer cycle
    input  wire        pll_enable,       // PLL enabled, from outside
    input  wire [5:0]  pair_done,        // Pair conversion complete pulses
    output reg         conv_clk_en,      // Converter clock pulse
    output reg  [5:0]  pair_ready,       // Pair flags to the core
    output reg  [7:0]  base_upper,       // Result base pointer high byte
    output reg         irq               // Level interrupt
);

    // Register map, one 32-bit word each, registers in the low 16 bits:
    //   0x00 control: select in 2:0, run in 15, other bits plain storage
    //   0x04 pair status: ready flags in 5:0, writing zero clears a flag
    //   0x08 base pointer: upper byte in 15:8, low byte reads zero
    //   0x0c interrupt mask: one enable per pair in 5:0
    //   0x10 interrupt status: sticky pair events, write one to clear
    //   0x14 divider state, read only: divisor in 4:0, PLL state in 8
    // Any other address reads zero and ignores writes.
    // Status, mask and interrupt status writes need byte lane 0;
    // base pointer writes need lane 1. Unused lanes keep their bits.

    // Register state
    reg  [15:0] control_r;
    reg  [7:0]  base_r;
    reg  [5:0]  irq_mask_r;
    reg  [5:0]  irq_stat_r;
    reg  [31:0] rdata_nxt;

    // Bus handshake state: idle, or answering the request just taken
    localparam  BUS_IDLE   = 1'b0;
    localparam  BUS_ANSWER = 1'b1;
    reg         bus_state_r;
    reg         bus_state_nxt;
    reg         wait_nxt;
    wire        answering;
    wire        req;
    wire        wr_go;
    wire        rd_go;

    // Synchroniser for the PLL level
    reg         pll_meta_r;
    reg         pll_sync_r;

    // Submodule outputs
    wire [5:0]  flags;
    wire [4:0]  div_eff;
    wire        clk_en;

    // Decoded write strobes
    wire        wr_control;
    wire        wr_status;
    wire        wr_base;
    wire        wr_mask;
    wire        wr_istat;

    // Next values of the registers and of the interrupt level
    wire [15:0] control_nxt;
    wire [7:0]  base_nxt;
    reg  [5:0]  irq_mask_nxt;
    reg  [5:0]  irq_stat_nxt;
    wire        irq_nxt;

    // Control fields, flag clear strobe and divider state word
    wire        conv_run;
    wire [2:0]  div_sel;
    wire        flags_clr_wr;
    wire [31:0] div_state_word;

    // PLL state crosses from outside through two flops
    always @(posedge clk_sys) begin
        if (rst) begin
            pll_meta_r <= 1'b0;
            pll_sync_r <= 1'b0;
        end else begin
            pll_meta_r <= pll_enable;
            pll_sync_r <= pll_meta_r;
        end
    end

    // A request is answered one cycle after it appears
    assign req       = avs_read || avs_write;
    assign answering = (bus_state_r == BUS_ANSWER);
    assign wr_go     = avs_write && answering;
    assign rd_go     = avs_read && !answering && avs_waitrequest;

    // Next bus state; the answer cycle always returns to idle, so a
    // request held too long is taken again rather than chained
    always @* begin
        bus_state_nxt = bus_state_r;
        wait_nxt      = 1'b1;
        case (bus_state_r)
            BUS_IDLE: begin
                if (req) begin
                    bus_state_nxt = BUS_ANSWER;
                    wait_nxt      = 1'b0;
                end
            end
            BUS_ANSWER: begin
                bus_state_nxt = BUS_IDLE;
            end
            default: begin
                bus_state_nxt = BUS_IDLE;
            end
        endcase
    end

    // Waitrequest drops for exactly one cycle per request
    always @(posedge clk_sys) begin
        if (rst) begin
            bus_state_r     <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end else begin
            bus_state_r     <= bus_state_nxt;
            avs_waitrequest <= wait_nxt;
        end
    end

    // Writes take effect on the edge the master sees waitrequest low
    assign wr_control = wr_go && (avs_address == `ACDP_OFS_CONTROL);
    assign wr_status  = wr_go && (avs_address == `ACDP_OFS_PAIR_STATUS);
    assign wr_base    = wr_go && (avs_address == `ACDP_OFS_BASE);
    assign wr_mask    = wr_go && (avs_address == `ACDP_OFS_IRQ_MASK);
    assign wr_istat   = wr_go && (avs_address == `ACDP_OFS_IRQ_STATUS);

    // Byte lanes merge into the control word, one lane at a time
    genvar lane;
    generate
        for (lane = 0; lane < 2; lane = lane + 1) begin : g_ctl_lane
            assign control_nxt[lane*8 +: 8] =
                avs_byteenable[lane] ? avs_writedata[lane*8 +: 8]
                                     : control_r[lane*8 +: 8];
        end
    endgenerate

    // Control fields feeding the divider
    assign conv_run = control_r[`ACDP_CTL_ON_BIT];
    assign div_sel  = control_r[`ACDP_CTL_SEL_MSB:`ACDP_CTL_SEL_LSB];

    // A status write without lane 0 clears nothing
    assign flags_clr_wr = wr_status && avs_byteenable[0];

    // Divider state word: divisor in force and synchronised PLL state
    assign div_state_word = {23'h000000, pll_sync_r, 3'h0, div_eff};

    // Only the upper byte of the base pointer is held here
    assign base_nxt = avs_byteenable[1] ?
                      avs_writedata[`ACDP_BASE_MSB:`ACDP_BASE_LSB] : base_r;

    // Control and base registers
    always @(posedge clk_sys) begin
        if (rst) begin
            control_r <= `ACDP_RST_CONTROL;
            base_r    <= `ACDP_RST_BASE;
        end else begin
            if (wr_control) begin
                control_r <= control_nxt;
            end
            if (wr_base) begin
                base_r <= base_nxt;
            end
        end
    end

    // Mask and sticky event bits; lane 0 carries all six bits
    always @* begin
        irq_mask_nxt = irq_mask_r;
        irq_stat_nxt = irq_stat_r | pair_done;
        if (wr_mask && avs_byteenable[0]) begin
            irq_mask_nxt = avs_writedata[5:0];
        end
        // Write one to clear; a new event wins the clear, none is lost
        if (wr_istat && avs_byteenable[0]) begin
            irq_stat_nxt = (irq_stat_r & ~avs_writedata[5:0]) | pair_done;
        end
    end

    // Interrupt mask and status registers
    always @(posedge clk_sys) begin
        if (rst) begin
            irq_mask_r <= `ACDP_RST_IRQ_MASK;
            irq_stat_r <= `ACDP_RST_IRQ_STATUS;
        end else begin
            irq_mask_r <= irq_mask_nxt;
            irq_stat_r <= irq_stat_nxt;
        end
    end

    // Interrupt level: any unmasked sticky event
    assign irq_nxt = |(irq_stat_r & irq_mask_r);

    // Divider steps the converter clock from the select field. The PLL
    // state reaches it two or three cycles after the pin moves, so the
    // first period after a change may still follow the old ratio.
    acdp_clk_div u_div (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .run       (conv_run),
        .pll_on    (pll_sync_r),
        .div_sel   (div_sel),
        .div_eff_r (div_eff),
        .clk_en_r  (clk_en)
    );

    // Ready flags; set and clear meet on the edge the write lands, and
    // the flag module lets the set win
    acdp_pair_flags u_flags (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .pair_done (pair_done),
        .clr_wr    (flags_clr_wr),
        .clr_data  (avs_writedata[5:0]),
        .flags_r   (flags)
    );

    // Read multiplexer; unmapped addresses and spare bits read zero
    always @* begin
        rdata_nxt = 32'h0000_0000;
        case (avs_address)
            `ACDP_OFS_CONTROL: begin
                rdata_nxt[15:0] = control_r;
            end
            `ACDP_OFS_PAIR_STATUS: begin
                rdata_nxt[5:0] = flags;
            end
            `ACDP_OFS_BASE: begin
                rdata_nxt[`ACDP_BASE_MSB:`ACDP_BASE_LSB] = base_r;
            end
            `ACDP_OFS_IRQ_MASK: begin
                rdata_nxt[5:0] = irq_mask_r;
            end
            `ACDP_OFS_IRQ_STATUS: begin
                rdata_nxt[5:0] = irq_stat_r;
            end
            `ACDP_OFS_DIV_STATE: begin
                rdata_nxt = div_state_word;
            end
            default: begin
                rdata_nxt = 32'h0000_0000;
            end
        endcase
    end

    // Read data captured as waitrequest falls, held until the next read;
    // the master takes it one edge later, while it still stands
    always @(posedge clk_sys) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_go) begin
            avs_readdata <= rdata_nxt;
        end
    end

    // Outputs to the core all leave from flops
    always @(posedge clk_sys) begin
        if (rst) begin
            conv_clk_en <= 1'b0;
            pair_ready  <= `ACDP_RST_PAIR_STATUS;
            base_upper  <= `ACDP_RST_BASE;
        end else begin
            conv_clk_en <= clk_en;
            pair_ready  <= flags;
            base_upper  <= base_r;
        end
    end

    // Interrupt leaves from its own flop, one cycle behind the status
    always @(posedge clk_sys) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_nxt;
        end
    end

endmodule // acdp_top

// ===== shared/acdp_regs.vh
// Register map, field layout, reset values and divider counts of the
// paired-input converter control block.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word a register.
`ifndef ACDP_REGS_VH
`define ACDP_REGS_VH

// Byte offsets of the registers
`define ACDP_OFS_CONTROL     8'h00
`define ACDP_OFS_PAIR_STATUS 8'h04
`define ACDP_OFS_BASE        8'h08
`define ACDP_OFS_IRQ_MASK    8'h0c
`define ACDP_OFS_IRQ_STATUS  8'h10
`define ACDP_OFS_DIV_STATE   8'h14

// Control register fields
`define ACDP_CTL_SEL_LSB     0
`define ACDP_CTL_SEL_MSB     2
`define ACDP_CTL_ON_BIT      15

// Base register: only the upper byte is held
`define ACDP_BASE_LSB        8
`define ACDP_BASE_MSB        15

// Pair flags
`define ACDP_NUM_PAIRS       6

// Reset values
`define ACDP_RST_CONTROL     16'h0000
`define ACDP_RST_PAIR_STATUS 6'h00
`define ACDP_RST_BASE        8'h00
`define ACDP_RST_IRQ_MASK    6'h00
`define ACDP_RST_IRQ_STATUS  6'h00

// Divider counts in source clock cycles
`define ACDP_DIV_BASE        5'h04
`define ACDP_DIV_PLL_FLOOR   5'h08
`define ACDP_SEL_PLL_MIN     3'h2

`endif

// ===== rtl/acdp_clk_div.v
// Converter clock divider: one-cycle enable pulse every N source cycles.
// Assumes select and PLL state are stable levels on the system clock.
`timescale 1ns/1ps
`include "acdp_regs.vh"

module acdp_clk_div (
    input  wire       clk_sys,    // Source clock
    input  wire       rst,        // Synchronous reset, active high
    input  wire       run,        // Divider enabled
    input  wire       pll_on,     // PLL enabled, synchronised
    input  wire [2:0] div_sel,    // Divider select code
    output reg  [4:0] div_eff_r,  // Divisor in force
    output reg        clk_en_r    // One-cycle converter clock pulse
);

    reg  [4:0] cnt_r;
    reg  [4:0] div_nxt;

    // Divisor is four plus twice the code; low codes fold with PLL on
    always @* begin
        div_nxt = `ACDP_DIV_BASE + {1'b0, div_sel, 1'b0};
        if (pll_on && (div_sel < `ACDP_SEL_PLL_MIN)) begin
            div_nxt = `ACDP_DIV_PLL_FLOOR;
        end
    end

    // Counter restarts when stopped, so a new ratio starts clean
    always @(posedge clk_sys) begin
        if (rst) begin
            cnt_r     <= 5'h00;
            clk_en_r  <= 1'b0;
            div_eff_r <= `ACDP_DIV_BASE;
        end else begin
            div_eff_r <= div_nxt;
            clk_en_r  <= 1'b0;
            if (!run) begin
                cnt_r <= 5'h00;
            end else if (cnt_r >= div_nxt - 5'h01) begin
                cnt_r    <= 5'h00;
                clk_en_r <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 5'h01;
            end
        end
    end

endmodule // acdp_clk_div

// ===== rtl/acdp_pair_flags.v
// Six pair-ready flags: set by the converter core, cleared by writing zero.
// Assumes done pulses come from logic on the same clock.
`timescale 1ns/1ps
`include "acdp_regs.vh"

module acdp_pair_flags (
    input  wire       clk_sys,    // System clock
    input  wire       rst,        // Synchronous reset, active high
    input  wire [5:0] pair_done,  // Pair results placed in buffer
    input  wire       clr_wr,     // Write to the status register
    input  wire [5:0] clr_data,   // Written value, zero clears
    output reg  [5:0] flags_r     // Ready flags
);

    genvar i;

    // One flag per pair; a set in the clearing cycle wins
    generate
        for (i = 0; i < `ACDP_NUM_PAIRS; i = i + 1) begin : g_flag
            always @(posedge clk_sys) begin
                if (rst) begin
                    flags_r[i] <= 1'b0;
                end else if (pair_done[i]) begin
                    flags_r[i] <= 1'b1;
                end else if (clr_wr && !clr_data[i]) begin
                    flags_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule // acdp_pair_flags

// ===== tb/acdp_core_model.sv
// Converter core model: pulses pair_done a set delay after a start.
// Assumes start and dly come from the bench on clk_sys.
`timescale 1ns/1ps
module acdp_core_model (
    input  wire       clk_sys,   // Clock
    input  wire       rst,       // Reset
    input  wire [5:0] start,     // Pairs to convert
    input  wire [3:0] dly,       // Cycles to completion
    output wire [5:0] pair_done  // Completion pulses
);
    reg [5:0] msk_r;
    reg [3:0] cnt_r;
    // One conversion in flight; a new start replaces it
    always @(posedge clk_sys) begin
        if (rst) begin
            cnt_r <= 4'h0;
            msk_r <= 6'h00;
        end else if (start != 6'h00) begin
            cnt_r <= dly;
            msk_r <= start;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
    // Results land for one cycle only, never held
    assign pair_done = (cnt_r == 4'h1) ? msk_r : 6'h00;
endmodule // acdp_core_model

// ===== tb/acdp_props.sv
// Checker on the ports of acdp_top.
// Assumes all bus writes use every byte lane.
`timescale 1ns/1ps
module acdp_props (
    input wire        clk_sys,         // Clock
    input wire        rst,             // Reset
    input wire [7:0]  avs_address,     // Address
    input wire        avs_read,        // Read
    input wire        avs_write,       // Write
    input wire [31:0] avs_writedata,   // Write data
    input wire [31:0] avs_readdata,    // Read data
    input wire        avs_waitrequest, // Stall
    input wire        pll_enable,      // PLL on
    input wire [5:0]  pair_done,       // Set pulses
    input wire        conv_clk_en,     // Divider pulse
    input wire [5:0]  pair_ready       // Flags
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    reg [5:0] pll_cnt_r;
    // Cycles since PLL on; margin covers the synchroniser and a stale period
    always @(posedge clk_sys) begin
        if (rst || !pll_enable)
            pll_cnt_r <= 6'h00;
        else if (pll_cnt_r != 6'h3f)
            pll_cnt_r <= pll_cnt_r + 6'h01;
    end
    sequence s_st_wr;
        avs_write && !avs_waitrequest && avs_address == 8'h04;
    endsequence
    sequence s_st_rd;
        avs_read && !avs_waitrequest && avs_address == 8'h04;
    endsequence
    property p_set;
        pair_done != 6'h00 |-> ##2
            (pair_ready & $past(pair_done, 2)) == $past(pair_done, 2);
    endproperty
    a_set: assert property (p_set) else $error("flag not set");
    property p_fall;
        ($past(pair_ready) & ~pair_ready) != 6'h00 |->
            $past(avs_write && !avs_waitrequest && avs_address == 8'h04, 2);
    endproperty
    a_fall: assert property (p_fall) else $error("flag lost");
    property p_clear;
        s_st_wr |-> ##2 (pair_ready & ~$past(avs_writedata[5:0], 2)
            & ~$past(pair_done, 2)) == 6'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("no clear");
    property p_coll;
        s_st_wr ##0 pair_done != 6'h00 |-> ##2
            (pair_ready & $past(pair_done, 2)) == $past(pair_done, 2);
    endproperty
    a_coll: assert property (p_coll) else $error("set lost");
    property p_upper;
        s_st_rd |-> avs_readdata[31:6] == 26'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper bits");
    property p_min4;
        conv_clk_en |=> !conv_clk_en [*3];
    endproperty
    a_min4: assert property (p_min4) else $error("period short");
    property p_min8;
        conv_clk_en && pll_cnt_r > 6'h28 |=> !conv_clk_en [*7];
    endproperty
    a_min8: assert property (p_min8) else $error("pll period");
    property p_gap;
        conv_clk_en |-> ##[1:40] conv_clk_en;
    endproperty
    a_gap: assert property (p_gap) else $error("period long");
endmodule // acdp_props

bind acdp_top acdp_props u_props (.clk_sys, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .pll_enable, .pair_done, .conv_clk_en, .pair_ready);

// ===== tb/acdp_bench.sv
// Bench: bus tasks, core model, random flag and interrupt traffic.
// Assumes the checker binds itself to acdp_top.
`timescale 1ns/1ps
module acdp_bench;
    reg         clk_sys = 1'b0, rst = 1'b1, pll_enable = 1'b0;
    reg         avs_read = 1'b0, avs_write = 1'b0;
    reg  [7:0]  avs_address = 8'h00;
    reg  [31:0] avs_writedata = 32'h0, q, v;
    reg  [5:0]  start = 6'h00, fl, is, mk, f;
    reg  [3:0]  dly = 4'h1;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, conv_clk_en, irq;
    wire [5:0]  pair_done, pair_ready;
    wire [7:0]  base_upper;
    integer     bad_count = 0, total_checks = 0, cyc = 0, i, n;
    acdp_top u_dut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
        .avs_waitrequest, .pll_enable, .pair_done, .conv_clk_en,
        .pair_ready, .base_upper, .irq);
    acdp_core_model u_core (.clk_sys, .rst, .start, .dly, .pair_done);
    // 10 MHz clock
    always #50 clk_sys = ~clk_sys;
    // Hang guard, far above the expected run
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            report_and_stop;
        end
    end
    function [31:0] exp_div(input [2:0] s, input p);
        exp_div = (p && s < 3'h2) ? 32'h8 : 32'h4 + 2 * s;
    endfunction
    task chk(input [31:0] e, input [31:0] g, input [63:0] nm);
        begin
            total_checks = total_checks + 1;
            if (g !== e) begin
                bad_count = bad_count + 1;
                $display("ERROR %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // Held until waitrequest is seen low; fire starts the core alongside
    task acc(input w, input [7:0] a, input [31:0] d, input [5:0] fire);
        begin
            avs_read <= !w;
            avs_write <= w;
            avs_address <= a;
            avs_writedata <= d;
            start <= fire;
            @(posedge clk_sys);
            start <= 6'h00;
            while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
            q = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            @(posedge clk_sys);
        end
    endtask
    // Edges to the next divider pulse, bounded
    task gap;
        begin
            n = 1;
            @(posedge clk_sys);
            while (conv_clk_en !== 1'b1 && n < 40) begin
                @(posedge clk_sys);
                n = n + 1;
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", total_checks, bad_count);
            if (bad_count == 0 && total_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    initial begin
        v = $urandom(33);
        fl = 6'h00;
        is = 6'h00;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        acc(1'b0, 8'h04, 32'h0, 6'h00);
        chk(32'h0, q, "status");
        // Every select code, PLL off then on; first two gaps skip stale periods, third is measured
        for (i = 0; i < 16; i = i + 1) begin
            pll_enable <= i[3];
            acc(1'b1, 8'h00, {16'h0, 13'h1000, i[2:0]}, 6'h00);
            gap;
            gap;
            gap;
            chk(exp_div(i[2:0], i[3]), n, "divisor");
            v = exp_div(i[2:0], i[3]);
            acc(1'b0, 8'h14, 32'h0, 6'h00);
            chk({23'h0, i[3], 3'h0, v[4:0]}, q, "divstate");
            acc(1'b0, 8'h00, 32'h0, 6'h00);
            chk({16'h0, 13'h1000, i[2:0]}, q, "control");
        end
        v = $urandom;
        acc(1'b1, 8'h08, v, 6'h00);
        acc(1'b0, 8'h08, 32'h0, 6'h00);
        chk({16'h0, v[15:8], 8'h00}, q, "base");
        chk({24'h0, v[15:8]}, {24'h0, base_upper}, "base_out");
        // Random sets, clears racing sets, interrupt mask and clear
        for (i = 0; i < 16; i = i + 1) begin
            mk = $urandom;
            acc(1'b1, 8'h0c, {26'h0, mk}, 6'h00);
            f = $urandom;
            dly <= 4'h1 + $urandom % 8;
            acc(1'b0, 8'h20, 32'h0, f);
            chk(32'h0, q, "unmapped");
            repeat (10) @(posedge clk_sys);
            fl = fl | f;
            is = is | f;
            v = (i == 0) ? 32'h0 : $urandom;
            f = $urandom;
            dly <= 4'h1;
            acc(1'b1, 8'h04, v, f);
            fl = (fl & v[5:0]) | f;
            is = is | f;
            v = $urandom;
            acc(1'b1, 8'h10, v, 6'h00);
            is = is & ~v[5:0];
            acc(1'b0, 8'h04, 32'h0, 6'h00);
            chk({26'h0, fl}, q, "status");
            chk({26'h0, fl}, {26'h0, pair_ready}, "ready");
            chk({31'h0, |(is & mk)}, {31'h0, irq}, "irq");
            acc(1'b0, 8'h10, 32'h0, 6'h00);
            chk({26'h0, is}, q, "irq_stat");
            acc(1'b0, 8'h0c, 32'h0, 6'h00);
            chk({26'h0, mk}, q, "mask");
        end
        report_and_stop;
    end
endmodule // acdp_bench
